// ---- rtl/dcf_pkg.sv ----
// shared constants and types for the dual-clock fifo write side
package dcf_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned ADDR_W      = 4;
  localparam int unsigned APB_AW      = 8;
  localparam int unsigned CNT_W       = 16;
  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_OVFCNT   = 8'h08;
  // control field positions and reset value
  localparam int unsigned CTRL_ACK_EN  = 0;
  localparam int unsigned CTRL_ACK_POL = 1;
  localparam int unsigned CTRL_OVF_EN  = 2;
  localparam int unsigned CTRL_OVF_POL = 3;
  localparam logic [3:0]  CTRL_RESET   = 4'hF;
  // status field positions
  localparam int unsigned STAT_FULL    = 0;
  localparam int unsigned STAT_AFULL   = 1;
  localparam int unsigned STAT_WBUSY   = 2;
  localparam int unsigned STAT_RBUSY   = 3;
  localparam int unsigned STAT_LVL_LSB = 8;
  // reset synchroniser depth, in clock cycles
  localparam int unsigned SYNC_STAGES  = 2;

  typedef struct packed {
    logic ovf_pol;
    logic ovf_en;
    logic ack_pol;
    logic ack_en;
  } dcf_ctrl_t;

  typedef struct packed {
    logic full;
    logic almost_full;
    logic wr_ack;
    logic overflow;
  } dcf_wflags_t;
endpackage

// ---- rtl/dcf_rst_sync.sv ----
// reset synchroniser: asserts at once, releases on the local clock
`timescale 1ns/1ps
`default_nettype none
module dcf_rst_sync (
  input  wire logic clk,
  input  wire logic arst,
  output var  logic rst_out
);
  import dcf_pkg::*;
  logic [SYNC_STAGES-1:0] stage_ff;

  // stage 0 feeds only stage 1, so metastability stays inside the chain
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      stage_ff <= '1;
    end else begin
      stage_ff <= {stage_ff[SYNC_STAGES-2:0], 1'b0};
    end
  end

  assign rst_out = stage_ff[SYNC_STAGES-1];
endmodule
`default_nettype wire

// ---- rtl/dcf_gray_sync.sv ----
// two-flop synchroniser for a gray-coded pointer
`timescale 1ns/1ps
`default_nettype none
module dcf_gray_sync #(
  parameter int unsigned W = 5
) (
  input  wire logic         clk,
  input  wire logic         arst,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  import dcf_pkg::*;
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // one bit per lane; gray code keeps at most one lane in flight
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or posedge arst) begin
      if (arst) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else if (srst) begin
        meta_ff[i] <= 1'b0;
        sync_ff[i] <= 1'b0;
      end else begin
        meta_ff[i] <= d[i];
        sync_ff[i] <= meta_ff[i];
      end
    end
  end

  assign q = sync_ff;
endmodule
`default_nettype wire

// ---- rtl/dcf_write_fifo.sv ----
// dual-clock fifo with full write-side flags and an apb status port
`timescale 1ns/1ps
`default_nettype none
module dcf_write_fifo #(
  parameter int unsigned DATA_W    = dcf_pkg::DATA_W,
  parameter int unsigned ADDR_W    = dcf_pkg::ADDR_W,
  parameter bit          ASYNC_RST = 1'b1,
  parameter bit          BUILTIN   = 1'b0
) (
  input  wire logic                       CLK,
  input  wire logic                       RESET,
  input  wire logic                       ARST,
  input  wire logic                       RD_CLK,
  input  wire logic                       RD_RESET,
  input  wire logic                       WR_EN,
  input  wire logic [DATA_W-1:0]          DIN,
  output var  dcf_pkg::dcf_wflags_t       WR_FLAGS,
  output var  logic                       WR_RST_BUSY,
  input  wire logic                       RD_EN,
  output var  logic [DATA_W-1:0]          DOUT,
  output var  logic                       RD_RST_BUSY,
  input  wire logic                       PSEL,
  input  wire logic                       PENABLE,
  input  wire logic                       PWRITE,
  input  wire logic [dcf_pkg::APB_AW-1:0] PADDR,
  input  wire logic [31:0]                PWDATA,
  output var  logic [31:0]                PRDATA,
  output var  logic                       PREADY,
  output var  logic                       PSLVERR
);
  import dcf_pkg::*;

  localparam int unsigned PW = ADDR_W + 1;
  localparam logic [PW-1:0] DEPTH_L  = PW'(1 << ADDR_W);
  localparam logic [PW-1:0] AFULL_L  = PW'((1 << ADDR_W) - 1);
  localparam logic [PW-1:0] ONE_L    = PW'(1);

  function automatic logic [PW-1:0] g2b(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // ---------------- resets ----------------
  logic wr_arst;
  logic wr_srst;
  logic rd_arst;
  logic rd_srst;
  logic wr_rst;
  logic rd_rst;

  if (ASYNC_RST) begin : g_async
    // asserts without a clock, releases cleanly in each domain
    dcf_rst_sync u_wr_rs (
      .clk     (CLK),
      .arst    (ARST),
      .rst_out (wr_arst)
    );
    dcf_rst_sync u_rd_rs (
      .clk     (RD_CLK),
      .arst    (ARST),
      .rst_out (rd_arst)
    );
    assign wr_srst = 1'b0;
    assign rd_srst = 1'b0;
  end else begin : g_sync
    // each domain stays cleared while its own input is high
    assign wr_arst = 1'b0;
    assign rd_arst = 1'b0;
    assign wr_srst = RESET;
    assign rd_srst = RD_RESET;
  end
  assign wr_rst = wr_arst | wr_srst;
  assign rd_rst = rd_arst | rd_srst;

  // ---------------- storage ----------------
  // no reset on the array; pointers start equal so it never matters
  logic [DATA_W-1:0] mem_ff [1 << ADDR_W];

  // ---------------- write domain ----------------
  logic [PW-1:0] wr_bin_ff  = '0;
  logic [PW-1:0] wr_gray_ff = '0;
  logic          full_ff    = 1'b0;
  logic          afull_ff   = 1'b0;
  logic          ack_ff     = 1'b0;
  logic          ovf_ff     = 1'b0;
  logic          wbusy_ff   = 1'b0;
  dcf_ctrl_t     ctrl_ff    = dcf_ctrl_t'(CTRL_RESET);
  logic [CNT_W-1:0] ovf_cnt_ff = '0;
  logic [PW-1:0] rd_gray_ff = '0;

  logic [PW-1:0] rd_gray_w;
  logic [PW-1:0] rd_bin_w;
  logic          write_ok;
  logic          write_bad;
  logic [PW-1:0] nxt_wr_bin;
  logic [PW-1:0] level_w;
  logic          nxt_full;
  logic          nxt_afull;
  logic          nxt_ack;
  logic          nxt_ovf;

  dcf_gray_sync #(.W(PW)) u_rd2wr (
    .clk  (CLK),
    .arst (wr_arst),
    .srst (wr_srst),
    .d    (rd_gray_ff),
    .q    (rd_gray_w)
  );
  assign rd_bin_w = g2b(rd_gray_w);

  // busy cycle after release also blocks writes
  assign write_ok   = WR_EN & ~full_ff & ~wbusy_ff;
  assign write_bad  = WR_EN & full_ff & ~wbusy_ff;
  assign nxt_wr_bin = wr_bin_ff + PW'(write_ok);
  // read side seen late, so full clears a few cycles after a read
  assign level_w    = nxt_wr_bin - rd_bin_w;
  assign nxt_full   = (level_w == DEPTH_L);
  assign nxt_afull  = !BUILTIN && (level_w == AFULL_L);
  // disabled flag parks at its inactive level
  assign nxt_ack = ctrl_ff.ack_en ? (write_ok ~^ ctrl_ff.ack_pol)
                                  : ~ctrl_ff.ack_pol;
  assign nxt_ovf = ctrl_ff.ovf_en ? (write_bad ~^ ctrl_ff.ovf_pol)
                                  : ~ctrl_ff.ovf_pol;

  always_ff @(posedge CLK) begin
    if (write_ok) begin
      mem_ff[wr_bin_ff[ADDR_W-1:0]] <= DIN;
    end
  end

  always_ff @(posedge CLK or posedge wr_arst) begin
    if (wr_arst) begin
      wr_bin_ff  <= '0;
      wr_gray_ff <= '0;
      full_ff    <= 1'b0;
      afull_ff   <= 1'b0;
      wbusy_ff   <= 1'b1;
    end else if (wr_srst) begin
      wr_bin_ff  <= '0;
      wr_gray_ff <= '0;
      full_ff    <= 1'b0;
      afull_ff   <= 1'b0;
      wbusy_ff   <= 1'b1;
    end else begin
      wr_bin_ff  <= nxt_wr_bin;
      wr_gray_ff <= nxt_wr_bin ^ (nxt_wr_bin >> 1);
      full_ff    <= nxt_full;
      afull_ff   <= nxt_afull;
      wbusy_ff   <= 1'b0;
    end
  end

  // handshake flags reset to 0, the inactive level of the reset control; a sync clear uses the inactive level of the current control
  always_ff @(posedge CLK or posedge wr_arst) begin
    if (wr_arst) begin
      ack_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else if (wr_srst) begin
      ack_ff <= ~ctrl_ff.ack_pol;
      ovf_ff <= ~ctrl_ff.ovf_pol;
    end else begin
      ack_ff <= nxt_ack;
      ovf_ff <= nxt_ovf;
    end
  end

  assign WR_FLAGS.full        = full_ff;
  assign WR_FLAGS.almost_full = afull_ff;
  assign WR_FLAGS.wr_ack      = ack_ff;
  assign WR_FLAGS.overflow    = ovf_ff;
  assign WR_RST_BUSY          = wbusy_ff;

  // ---------------- read domain ----------------
  logic [PW-1:0]     rd_bin_ff  = '0;
  logic [DATA_W-1:0] dout_ff    = '0;
  logic              rbusy_ff   = 1'b0;
  logic [PW-1:0]     wr_gray_r;
  logic [PW-1:0]     wr_bin_r;
  logic              rd_empty;
  logic              read_ok;
  logic [PW-1:0]     nxt_rd_bin;

  dcf_gray_sync #(.W(PW)) u_wr2rd (
    .clk  (RD_CLK),
    .arst (rd_arst),
    .srst (rd_srst),
    .d    (wr_gray_ff),
    .q    (wr_gray_r)
  );
  assign wr_bin_r   = g2b(wr_gray_r);
  assign rd_empty   = (rd_bin_ff == wr_bin_r);
  assign read_ok    = RD_EN & ~rd_empty & ~rbusy_ff;
  assign nxt_rd_bin = rd_bin_ff + PW'(read_ok);

  always_ff @(posedge RD_CLK or posedge rd_arst) begin
    if (rd_arst) begin
      rd_bin_ff  <= '0;
      rd_gray_ff <= '0;
      dout_ff    <= '0;
      rbusy_ff   <= 1'b1;
    end else if (rd_srst) begin
      rd_bin_ff  <= '0;
      rd_gray_ff <= '0;
      dout_ff    <= '0;
      rbusy_ff   <= 1'b1;
    end else begin
      rd_bin_ff  <= nxt_rd_bin;
      rd_gray_ff <= nxt_rd_bin ^ (nxt_rd_bin >> 1);
      rbusy_ff   <= 1'b0;
      if (read_ok) begin
        dout_ff <= mem_ff[rd_bin_ff[ADDR_W-1:0]];
      end
    end
  end
  assign DOUT        = dout_ff;
  assign RD_RST_BUSY = rbusy_ff;

  // ---------------- apb slave on the write clock ----------------
  // read-side busy is brought over before software sees it
  logic        rbusy_meta_ff = 1'b1;
  logic        rbusy_sync_ff = 1'b1;
  logic        pready_ff     = 1'b0;
  logic        pslverr_ff    = 1'b0;
  logic [31:0] prdata_ff     = '0;
  logic        apb_setup;
  logic        apb_wr;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_ovfc;
  logic        addr_hit;
  logic        ovfc_clr;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  logic [CNT_W-1:0] nxt_ovf_cnt;

  assign apb_setup = PSEL & ~PENABLE;
  assign apb_wr    = PSEL & PENABLE & PWRITE & pready_ff;
  assign hit_ctrl  = (PADDR == REG_CTRL);
  assign hit_stat  = (PADDR == REG_STATUS);
  assign hit_ovfc  = (PADDR == REG_OVFCNT);
  assign addr_hit  = hit_ctrl | hit_stat | hit_ovfc;
  assign ovfc_clr  = apb_wr & hit_ovfc;

  always_comb begin
    stat_word = '0;
    stat_word[STAT_FULL]  = full_ff;
    stat_word[STAT_AFULL] = afull_ff;
    stat_word[STAT_WBUSY] = wbusy_ff;
    stat_word[STAT_RBUSY] = rbusy_sync_ff;
    stat_word[STAT_LVL_LSB +: PW] = wr_bin_ff - rd_bin_w;
  end

  assign rd_mux = hit_ctrl ? 32'(ctrl_ff) :
                  hit_stat ? stat_word :
                  hit_ovfc ? 32'(ovf_cnt_ff) : 32'h0000_0000;
  // a new overflow in the clearing cycle still counts once
  assign nxt_ovf_cnt = ovfc_clr ? CNT_W'(write_bad)
                                : ovf_cnt_ff + CNT_W'(write_bad);

  always_ff @(posedge CLK or posedge wr_arst) begin
    if (wr_arst) begin
      rbusy_meta_ff <= 1'b1;
      rbusy_sync_ff <= 1'b1;
    end else begin
      rbusy_meta_ff <= rbusy_ff;
      rbusy_sync_ff <= rbusy_meta_ff;
    end
  end

  always_ff @(posedge CLK or posedge wr_arst) begin
    if (wr_arst) begin
      ctrl_ff    <= dcf_ctrl_t'(CTRL_RESET);
      ovf_cnt_ff <= '0;
    end else if (wr_srst) begin
      ctrl_ff    <= dcf_ctrl_t'(CTRL_RESET);
      ovf_cnt_ff <= '0;
    end else begin
      if (apb_wr && hit_ctrl) begin
        ctrl_ff <= dcf_ctrl_t'(PWDATA[3:0]);
      end
      ovf_cnt_ff <= nxt_ovf_cnt;
    end
  end

  // one wait-free access phase: pready rises right after setup
  always_ff @(posedge CLK or posedge wr_arst) begin
    if (wr_arst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & ~addr_hit;
      if (apb_setup && !PWRITE) begin
        prdata_ff <= rd_mux;
      end
    end
  end
  assign PREADY  = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign PRDATA  = prdata_ff;

  // ---------------- checks ----------------
  logic std_pol;
  assign std_pol = (ctrl_ff == dcf_ctrl_t'(CTRL_RESET));

  ack_on_write_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    write_ok && std_pol |=> ack_ff && !ovf_ff)
    else $error("write accepted without acknowledge");

  ovf_on_full_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    write_bad && std_pol |=> ovf_ff && !ack_ff)
    else $error("write while full not flagged as overflow");

  full_no_change_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    WR_EN && full_ff |=> $stable(wr_bin_ff) && $stable(wr_gray_ff))
    else $error("write while full moved the write pointer");

  write_next_edge_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    write_ok |=> wr_bin_ff == $past(wr_bin_ff) + ONE_L)
    else $error("accepted write did not advance the pointer");

  full_hold_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    full_ff && rd_bin_w == $past(rd_bin_w) |=> full_ff)
    else $error("full dropped with no read seen");

  afull_one_left_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    afull_ff |-> !full_ff && (wr_bin_ff - $past(rd_bin_w)) == AFULL_L)
    else $error("almost full without exactly one free entry");

  idle_no_flags_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    !WR_EN && std_pol |=> !ack_ff && !ovf_ff)
    else $error("handshake flag raised with no write attempt");

  no_builtin_afull_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    BUILTIN |-> !afull_ff)
    else $error("almost full raised in built-in variant");

  busy_release_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    $fell(wr_rst) |-> wbusy_ff ##1 !wbusy_ff)
    else $error("write busy not held exactly one cycle after reset");

  gray_one_step_a: assert property (
    @(posedge RD_CLK) disable iff (rd_rst)
    $countones(rd_gray_ff ^ $past(rd_gray_ff)) <= 1)
    else $error("read gray pointer changed more than one bit");

  apb_ready_a: assert property (
    @(posedge CLK) disable iff (wr_rst)
    apb_setup |=> pready_ff ##1 !pready_ff)
    else $error("apb access not answered in one cycle");

  fill_to_full_c: cover property (
    @(posedge CLK) disable iff (wr_rst) $rose(full_ff));
  overflow_seen_c: cover property (
    @(posedge CLK) disable iff (wr_rst) write_bad);
  refill_after_read_c: cover property (
    @(posedge CLK) disable iff (wr_rst) $fell(full_ff) ##[1:20] write_ok);
  apb_ctrl_write_c: cover property (
    @(posedge CLK) disable iff (wr_rst) apb_wr && hit_ctrl);
endmodule
`default_nettype wire

// ---- testbench/dcf_consumer.sv ----
// read-clock consumer model that pulls a requested number of words
`timescale 1ns/1ps
`default_nettype none
module dcf_consumer (
  input  wire logic        rd_clk,
  input  wire logic        arst,
  input  wire logic        rst_busy,
  input  wire logic        slow,
  input  wire logic [15:0] req_total,
  output var  logic        rd_en,
  output var  logic        got
);
  logic [15:0] done_ff;
  logic        gap_ff;
  wire         want = !rst_busy && (done_ff != req_total) && !gap_ff;
  // read enable only on its own clock
  always @(posedge rd_clk or posedge arst) begin
    if (arst) begin
      rd_en   <= 1'b0;
      got     <= 1'b0;
      done_ff <= 16'h0000;
      gap_ff  <= 1'b0;
    end else begin
      got     <= rd_en;
      gap_ff  <= slow & ~gap_ff;
      // only words the bench knows are stored
      rd_en   <= want;
      done_ff <= done_ff + {15'h0000, want};
    end
  end
endmodule
`default_nettype wire

// ---- testbench/tb_dual_clock_fifo_write_side.sv ----
// self-checking bench for the dual-clock fifo write side
`timescale 1ns/1ps
`default_nettype none
module tb_dual_clock_fifo_write_side;
  import dcf_pkg::*;
  localparam int DEPTH = 16;
  logic        CLK = 0, RD_CLK = 0, RESET = 1, ARST = 1, RD_RESET = 1;
  logic        WR_EN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, slow = 0;
  logic [7:0]  DIN = 8'h00, PADDR = 8'h00, DOUT;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic        RD_EN, got, WR_RST_BUSY, RD_RST_BUSY, PREADY, PSLVERR, err;
  logic [15:0] req_total = 16'h0000;
  logic [3:0]  ctrl = CTRL_RESET;
  logic        prev_att = 0, prev_ok = 0;
  logic [7:0]  q[$];
  logic [7:0]  DOUT_S, exp_w;
  logic        WBUSY_S, RBUSY_S;
  dcf_wflags_t WR_FLAGS, WR_FLAGS_S;
  int          fail_count = 0, cmp_count = 0, ovf_n = 0, n;
  always #5 CLK = ~CLK;
  // unrelated read clock, 13.7 ns period
  always #6.85 RD_CLK = ~RD_CLK;
  dcf_write_fifo dut (.CLK(CLK), .RESET(RESET), .ARST(ARST), .RD_CLK(RD_CLK),
    .RD_RESET(RD_RESET), .WR_EN(WR_EN), .DIN(DIN), .WR_FLAGS(WR_FLAGS),
    .WR_RST_BUSY(WR_RST_BUSY), .RD_EN(RD_EN), .DOUT(DOUT),
    .RD_RST_BUSY(RD_RST_BUSY), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR));
  dcf_consumer cons (.rd_clk(RD_CLK), .arst(ARST), .rst_busy(RD_RST_BUSY),
    .slow(slow), .req_total(req_total), .rd_en(RD_EN), .got(got));
  // second copy runs the per-domain synchronous clears
  dcf_write_fifo #(.ASYNC_RST(1'b0)) dut_s (.CLK(CLK), .RESET(RESET),
    .ARST(ARST), .RD_CLK(RD_CLK), .RD_RESET(RD_RESET), .WR_EN(WR_EN),
    .DIN(DIN), .WR_FLAGS(WR_FLAGS_S), .WR_RST_BUSY(WBUSY_S), .RD_EN(RD_EN),
    .DOUT(DOUT_S), .RD_RST_BUSY(RBUSY_S), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(),
    .PREADY(), .PSLVERR());
  // read-side clear follows the write one on its own clock
  always @(posedge RD_CLK)
    RD_RESET <= RESET;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic logic lvl(input logic en, input logic pol,
                               input logic pulse);
    return en ? (pulse ? pol : ~pol) : ~pol;
  endfunction
  // data leaves in write order
  always @(posedge RD_CLK)
    if (got === 1'b1) begin
      exp_w = q.pop_front();
      check({24'h0, DOUT}, {24'h0, exp_w});
      check({24'h0, DOUT_S}, {24'h0, exp_w});
    end
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 50);
    if (k >= 50)
      fail_count++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // one write-clock cycle; checks flags left by the previous attempt
  task automatic wr_step(input logic en);
    logic [7:0] d;
    logic       ok;
    dcf_wflags_t e;
    d = 8'($urandom);
    ok = en && q.size() < DEPTH;
    @(posedge CLK);
    WR_EN <= en;
    DIN <= d;
    @(negedge CLK);
    e.full        = q.size() == DEPTH;
    e.almost_full = q.size() == DEPTH - 1;
    e.wr_ack      = lvl(ctrl[0], ctrl[1], prev_att & prev_ok);
    e.overflow    = lvl(ctrl[2], ctrl[3], prev_att & ~prev_ok);
    check(WR_FLAGS.wr_ack, e.wr_ack);
    check(WR_FLAGS.overflow, e.overflow);
    check(WR_FLAGS.full, e.full);
    check(WR_FLAGS.almost_full, e.almost_full);
    check(WR_FLAGS_S, e);
    prev_att = en;
    prev_ok = ok;
    if (ok)
      q.push_back(d);
    if (en && !ok)
      ovf_n++;
  endtask
  task automatic wait_idle();
    for (n = 0; n < 30 && (WR_RST_BUSY !== 1'b0 || RD_RST_BUSY !== 1'b0); n++)
      @(negedge CLK);
    check({WR_RST_BUSY, RD_RST_BUSY}, 2'b00);
    check({WBUSY_S, RBUSY_S}, 2'b00);
    repeat (4) @(posedge CLK);
  endtask
  initial begin
    void'($urandom(20));
    repeat (19) @(posedge CLK);
    @(negedge CLK);
    check({WR_FLAGS, WR_RST_BUSY}, 5'h01);
    check({WR_FLAGS_S, WBUSY_S}, 5'h01);
    @(posedge CLK);
    ARST <= 1'b0;
    RESET <= 1'b0;
    wait_idle();
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, {28'h0, CTRL_RESET});
    check(err, 1'b0);
    $display("test reset done");
    repeat (DEPTH + 2) wr_step(1'b1);
    wr_step(1'b0);
    wr_step(1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h1F01, 32'h1001);
    apb(1'b0, REG_OVFCNT, 32'h0);
    check(rd, ovf_n);
    apb(1'b0, 8'h0C, 32'h0);
    check(err, 1'b1);
    $display("test fill and overflow done");
    n = q.size() - 3;
    req_total <= req_total + 16'd3;
    for (int i = 0; i < 200 && q.size() != n; i++)
      @(posedge CLK);
    check(q.size(), n);
    repeat (8) @(posedge CLK);
    wr_step(1'b0);
    repeat (4) wr_step(1'b1);
    wr_step(1'b0);
    $display("test refill done");
    apb(1'b1, REG_CTRL, 32'h1);
    ctrl = 4'h1;
    // still full: a disabled overflow flag must stay parked
    wr_step(1'b1);
    wr_step(1'b0);
    slow <= 1'b1;
    req_total <= req_total + 16'd16;
    for (int i = 0; i < 600 && q.size() != 0; i++)
      @(posedge CLK);
    check(q.size(), 0);
    repeat (8) @(posedge CLK);
    repeat (2) wr_step(1'b1);
    wr_step(1'b0);
    $display("test polarity done");
    @(posedge CLK);
    ARST <= 1'b1;
    RESET <= 1'b1;
    req_total <= 16'h0000;
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    check({WR_FLAGS, WR_RST_BUSY}, 5'h01);
    check({WR_FLAGS_S, WBUSY_S}, 5'h01);
    q.delete();
    ctrl = CTRL_RESET;
    prev_att = 0;
    @(posedge CLK);
    ARST <= 1'b0;
    RESET <= 1'b0;
    wait_idle();
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd & 32'h1F03, 32'h0);
    wr_step(1'b1);
    wr_step(1'b0);
    slow <= 1'b0;
    repeat (10) @(posedge CLK);
    req_total <= 16'd1;
    repeat (20) @(posedge CLK);
    check(q.size(), 0);
    $display("test async clear done");
    give_verdict();
  end
  initial begin
    #100us;
    fail_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
